// *** bhp_host_port.v ***
// Operation
// - host select lines pick the target register
// - read strobe: device drives the byte bus
// - write strobe: byte captured at strobe release
// - enabled request condition asserts service request
// - request released on clear, mask, DMA acknowledge, reset
// - DMA mode: acknowledge strobes port transfers
// - vector mode: acknowledge drives vector holder out
// - vector read ignores controls, keeps state
// - unused port pins become general purpose bits
// - request pin as gpio drives both levels
`timescale 1ns/10ps
`include "bhp_consts.vh"
module bhp_host_port
(
  input  wire       mclk,
  input  wire       rst,
  // pins (sampled through synchronisers)
  input  wire [2:0] hostRegSelect,
  input  wire       hostDirectionSelect,
  input  wire       hostStrobeEnableN,
  input  wire       hostAcknowledgeInputN,
  input  wire [7:0] hostByteBusIn,
  output reg  [7:0] hostByteBusOut,
  output reg        hostByteBusOe,
  output reg        hostServiceRequestOut,
  output reg        hostServiceRequestOe,
  // gpio pad side for pins PORT_B_GPIO_BITS (bit 0 = PB8)
  output reg  [6:0] gpioOut,
  output reg  [6:0] gpioOe,
  output reg  [6:0] gpioIn,
  // core side
  input  wire       portEnable,
  input  wire       ackIsDma,
  input  wire [7:0] vectorValue,
  input  wire       requestCondition,
  input  wire       requestMask,
  input  wire [6:0] gpioData,
  input  wire [6:0] gpioDir,
  input  wire [7:0] readData,
  output reg  [2:0] accessSelect,
  output reg        readStrobe,
  output reg        writeStrobe,
  output reg  [7:0] writeData,
  output reg        dmaStrobe
);

  wire [2:0] selS;
  wire       dirS;
  wire       strobeAS;
  wire       ackAS;
  wire [7:0] busS;
  // active-low pins pass the synchroniser inverted so that its reset
  // value reads as idle; otherwise reset would fake a strobe edge
  wire       strobeNS = ~strobeAS;
  wire       ackNS    = ~ackAS;

  bhp_pin_sync #(.WIDTH(14)) pinSync
  (
    .mclk   (mclk),
    .rst    (rst),
    .pinIn  ({hostRegSelect, hostDirectionSelect, ~hostStrobeEnableN,
              ~hostAcknowledgeInputN, hostByteBusIn}),
    .pinOut ({selS, dirS, strobeAS, ackAS, busS})
  );

  reg       strobePrevReg;
  reg       ackPrevReg;
  reg       dirLatchReg;
  reg [2:0] selLatchReg;
  reg       requestNext;

  wire strobeOn   = portEnable & ~strobeNS;
  wire strobeFall = strobeOn & strobePrevReg;
  wire strobeRise = portEnable & strobeNS & ~strobePrevReg;
  wire ackOn      = portEnable & ~ackNS;
  wire ackFall    = ackOn & ackPrevReg;
  wire ackRise    = portEnable & ackNS & ~ackPrevReg;
  // vector cycle only when the request was already out
  wire vecCycle   = ackOn & ~ackIsDma & hostServiceRequestOe;

  always @*
  begin
    requestNext = requestCondition & ~requestMask;
    if (ackOn & ackIsDma)
      requestNext = 1'b0;
  end

  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      strobePrevReg         <= 1'b1;
      ackPrevReg            <= 1'b1;
      dirLatchReg           <= 1'b0;
      selLatchReg           <= 3'h0;
      hostByteBusOut        <= `BHP_REG_RESET;
      hostByteBusOe         <= 1'b0;
      hostServiceRequestOut <= 1'b0;
      hostServiceRequestOe  <= 1'b0;
      gpioOut               <= 7'h00;
      gpioOe                <= 7'h00;
      gpioIn                <= 7'h00;
      accessSelect          <= 3'h0;
      readStrobe            <= 1'b0;
      writeStrobe           <= 1'b0;
      writeData             <= `BHP_REG_RESET;
      dmaStrobe             <= 1'b0;
    end
    else
    begin
      strobePrevReg <= strobeNS;
      ackPrevReg    <= ackNS;
      readStrobe    <= 1'b0;
      writeStrobe   <= 1'b0;
      dmaStrobe     <= 1'b0;
      if (!portEnable)
      begin
        // port pins handed over to the general purpose bits
        hostByteBusOe         <= 1'b0;
        hostServiceRequestOe  <= gpioDir[`BHP_GP_REQ];
        hostServiceRequestOut <= gpioData[`BHP_GP_REQ];
        gpioOut <= gpioData;
        gpioOe  <= gpioDir;
        gpioIn  <= {ackNS, 1'b0, strobeNS, dirS, selS};
      end
      else
      begin
        gpioOe <= 7'h00;
        // open drain: pull low when asserted, otherwise release
        hostServiceRequestOut <= 1'b0;
        hostServiceRequestOe  <= requestNext;
        if (vecCycle)
        begin
          // other controls ignored, no internal strobes raised
          hostByteBusOut <= vectorValue;
          hostByteBusOe  <= 1'b1;
        end
        else if (ackOn & ackIsDma)
        begin
          // DMA strobe uses the direction pin for the transfer sense
          if (ackFall)
          begin
            dirLatchReg <= dirS;
            if (dirS)
              dmaStrobe <= 1'b1;
          end
          hostByteBusOut <= readData;
          hostByteBusOe  <= dirLatchReg | (ackFall & dirS);
        end
        else if (strobeOn)
        begin
          if (strobeFall)
          begin
            selLatchReg  <= selS;
            dirLatchReg  <= dirS;
            accessSelect <= selS;
            if (dirS)
              readStrobe <= 1'b1;
          end
          hostByteBusOut <= readData;
          hostByteBusOe  <= strobeFall ? dirS : dirLatchReg;
        end
        else
          hostByteBusOe <= 1'b0;
        if (strobeRise & ~dirLatchReg & ~vecCycle)
        begin
          accessSelect <= selLatchReg;
          writeData    <= busS;
          writeStrobe  <= 1'b1;
        end
        if (ackRise & ackIsDma & ~dirLatchReg)
        begin
          writeData <= busS;
          dmaStrobe <= 1'b1;
        end
      end
    end
  end

endmodule // bhp_host_port

// *** bhp_consts.vh ***
`ifndef BHP_CONSTS_VH
`define BHP_CONSTS_VH
`define BHP_SEL_W        3
`define BHP_NREGS        8
`define BHP_GPIO_W       8
`define BHP_IVR_RESET    8'h0F
`define BHP_GPIO_RESET   8'h00
`define BHP_REG_RESET    8'h00
`define BHP_GP_SEL0      0
`define BHP_GP_DIR       3
`define BHP_GP_STROBE    4
`define BHP_GP_REQ       5
`define BHP_GP_ACK       6
`endif

// *** bhp_pin_sync.v ***
`timescale 1ns/10ps
// three-stage synchroniser; output moves only when stages two and three agree
module bhp_pin_sync
#(
  parameter WIDTH = 1
)
(
  input  wire             mclk,
  input  wire             rst,
  input  wire [WIDTH-1:0] pinIn,
  output reg  [WIDTH-1:0] pinOut
);

  reg [WIDTH-1:0] s1Reg;
  reg [WIDTH-1:0] s2Reg;
  reg [WIDTH-1:0] s3Reg;
  integer i;

  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      s1Reg  <= {WIDTH{1'b0}};
      s2Reg  <= {WIDTH{1'b0}};
      s3Reg  <= {WIDTH{1'b0}};
      pinOut <= {WIDTH{1'b0}};
    end
    else
    begin
      s1Reg <= pinIn;
      s2Reg <= s1Reg;
      s3Reg <= s2Reg;
      for (i = 0; i < WIDTH; i = i + 1)
        if (s2Reg[i] == s3Reg[i])
          pinOut[i] <= s3Reg[i];
    end
  end

endmodule // bhp_pin_sync

// *** bhp_host_port_properties.sv ***
`timescale 1ns/10ps
module bhp_port_chk
(
  input wire       mclk,
  input wire       rst,
  input wire       hostAcknowledgeInputN,
  input wire       portEnable,
  input wire       requestCondition,
  input wire       requestMask,
  input wire [6:0] gpioDir,
  input wire [6:0] gpioOe,
  input wire       hostByteBusOe,
  input wire       hostServiceRequestOut,
  input wire       hostServiceRequestOe,
  input wire       readStrobe,
  input wire       writeStrobe
);
  wire reqOn = portEnable && requestCondition && !requestMask;
  wire gpio  = !portEnable;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_req_set: assert property ((reqOn && hostAcknowledgeInputN)[*6]
    |-> hostServiceRequestOe) else $error("set");
  a_req_mask: assert property ((portEnable && requestMask)[*2]
    |-> !hostServiceRequestOe) else $error("mask");
  a_drain_low: assert property (portEnable[*3] ##0 hostServiceRequestOe
    |-> !hostServiceRequestOut) else $error("od");
  a_read_drive: assert property (readStrobe
    |-> hostByteBusOe ##1 !readStrobe) else $error("rd");
  a_write_float: assert property (writeStrobe
    |-> !hostByteBusOe ##1 !writeStrobe) else $error("wr");
  a_gpio_dir: assert property (gpio[*2]
    |-> ((gpioOe ^ $past(gpioDir)) & 7'h5F) == 7'h00) else $error("dir");
  a_gpio_quiet: assert property (gpio[*6]
    |-> !readStrobe && !writeStrobe) else $error("quiet");
  a_gpio_float: assert property (gpio[*2]
    |-> !hostByteBusOe) else $error("bus");
endmodule // bhp_port_chk
bind bhp_host_port bhp_port_chk chk_u (.mclk, .rst, .hostAcknowledgeInputN,
  .portEnable, .requestCondition, .requestMask, .gpioDir, .gpioOe,
  .hostByteBusOe, .hostServiceRequestOut, .hostServiceRequestOe,
  .readStrobe, .writeStrobe);

// *** bhp_host_model.sv ***
`timescale 1ns/10ps
module bhp_host_model
(
  input  wire       mclk,
  input  wire [7:0] hostByteBusOut,
  input  wire       hostByteBusOe,
  output reg  [2:0] hostRegSelect = 3'h0,
  output reg        hostDirectionSelect = 1'b0,
  output reg        hostStrobeEnableN = 1'b1,
  output reg        hostAcknowledgeInputN = 1'b1,
  output wire [7:0] hostByteBusIn
);
  reg [7:0] hd = 8'h00;
  reg       drv = 1'b0;
  // no pull on the bus: a floating line reads back inverted
  assign hostByteBusIn = hostByteBusOe ? hostByteBusOut : drv ? hd : ~hd;
  task xfer(input ack, input rd, input [2:0] a, input [7:0] d,
    output [7:0] q);
    @(negedge mclk);
    hostRegSelect = a;
    hostDirectionSelect = rd;
    hd = d;
    drv = !rd;
    if (ack) hostAcknowledgeInputN = 1'b0;
    else hostStrobeEnableN = 1'b0;
    repeat (8) @(negedge mclk);
    q = hostByteBusIn;
    hostStrobeEnableN = 1'b1;
    hostAcknowledgeInputN = 1'b1;
    repeat (6) @(negedge mclk);
    drv = 1'b0;
  endtask
endmodule // bhp_host_model

// *** tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
  reg        mclk = 1'b0, rst = 1'b1, portEnable = 1'b1, ackIsDma = 1'b0;
  reg        requestCondition = 1'b0, requestMask = 1'b0;
  reg  [7:0] vectorValue = 8'h00, readData = 8'h00, d, q;
  reg  [6:0] gpioData = 7'h00, gpioDir = 7'h00;
  reg  [2:0] a;
  wire [7:0] hostByteBusIn, hostByteBusOut, writeData;
  wire [6:0] gpioOut, gpioOe, gpioIn;
  wire       readStrobe, writeStrobe, dmaStrobe;
  integer    nRd = 0, nWr = 0, nDma = 0;
  wire [2:0] hostRegSelect, accessSelect;
  wire       hostDirectionSelect, hostStrobeEnableN, hostAcknowledgeInputN;
  wire       hostByteBusOe, hostServiceRequestOut, hostServiceRequestOe;
  integer    errTotal = 0, nTests = 0, cyc = 0, i, seed = 32'h32FE9645;
  bhp_host_port dut_u (.*);
  bhp_host_model host_u (.*);
  initial forever #20 mclk = ~mclk;
  always @(posedge mclk)
  begin
    nRd  <= nRd + readStrobe;
    nWr  <= nWr + writeStrobe;
    nDma <= nDma + dmaStrobe;
  end
  task chk(input string n, input [7:0] e, input [7:0] s);
    nTests++;
    if (s !== e)
    begin
      $display("ERROR %s exp %h got %h", n, e, s);
      errTotal++;
    end
  endtask
  task finishTest;
    if (errTotal == 0 && nTests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge mclk)
    if (++cyc > 3000)
    begin
      errTotal++;
      finishTest;
    end
  initial
  begin
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    for (i = 0; i < 16; i++)
    begin
      {a, d, readData} = 19'($random(seed));
      host_u.xfer(1'b0, i[0], a, d, q);
      chk("data", i[0] ? readData : d, i[0] ? q : writeData);
      chk("sel", {5'h00, a}, {5'h00, accessSelect});
    end
    chk("rdcnt", 8'h08, nRd[7:0]);
    chk("wrcnt", 8'h08, nWr[7:0]);
    requestCondition = 1'b1;
    vectorValue = 8'($random(seed));
    repeat (8) @(negedge mclk);
    chk("req", 8'h02, {6'h00, hostServiceRequestOe,
      hostServiceRequestOut});
    host_u.xfer(1'b1, 1'b1, ~a, d, q);
    chk("vec", vectorValue, q);
    chk("keep", {5'h00, a}, {5'h00, accessSelect});
    ackIsDma = 1'b1;
    host_u.xfer(1'b1, 1'b0, a, ~d, q);
    chk("dma", ~d, writeData);
    chk("dmacnt", 8'h01, nDma[7:0]);
    chk("wrkeep", 8'h08, nWr[7:0]);
    requestMask = 1'b1;
    repeat (3) @(negedge mclk);
    chk("mask", 8'h00, {7'h00, hostServiceRequestOe});
    portEnable = 1'b0;
    gpioDir = 7'($random(seed)) | 7'h20;
    gpioData = 7'($random(seed));
    repeat (3) @(negedge mclk);
    chk("gpio", {1'b0, gpioData}, {1'b0, gpioOut});
    chk("pb13", {7'h01, gpioData[5]}, {6'h00, hostServiceRequestOe,
      hostServiceRequestOut});
    chk("gpin", {2'h2, 1'b1, 1'b0, a}, {1'b0, gpioIn});
    finishTest;
  end
endmodule // tb_top
